/* File: sadc_sequencer.sv */
/*
 * Ten-bit successive-approximation converter control with an Avalon-MM
 * register slave: control register, split result registers, trial code
 * to a resistor-string DAC and a sampled comparator input.
 * Assumes clk is the CPU clock, cmp_in is asynchronous, and the analogue
 * mux follows analog_chan.
 */
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps

// Contract
// - three-bit channel field in control bits 6-4 picks one of eight inputs
// - exactly one channel is converted per conversion
// - writing control bit 0 as one starts a conversion
// - approximation register loads 200H at conversion start
// - one result bit decided per step, most significant first
// - first trial is the most significant bit alone, half reference
// - four clocks per bit plus ten set-up clocks, fifty in total
// - base speed conversion clock is four CPU clocks
// - two-bit speed field at control bits 2-1 picks conversion clock
// - at completion set end flag, store result, go idle
// - end flag at control bit 3 is read-only
// - upper eight result bits in high register, lower two in low
// - every completed conversion overwrites the result registers
// - control register at index F7H, whole-byte writes only
// - channel field may change between conversions
module sadc_sequencer
    import sadc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cmp_in,
    output logic      [9:0]  dac_code,
    output logic      [2:0]  analog_chan,
    output logic             conv_active
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sadc_state_e state_ff;
    sadc_state_e nxt_state;
    logic [2:0]  chan_ff;
    logic [1:0]  speed_ff;
    logic        start_ff;
    logic        eoc_ff;
    logic [2:0]  conv_chan_ff;
    logic [1:0]  conv_speed_ff;
    logic [9:0]  sar_ff;
    logic [9:0]  nxt_sar;
    logic [9:0]  result_ff;
    logic [3:0]  bit_ff;
    logic [3:0]  nxt_bit;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        cmp_meta_ff;
    logic        cmp_ff;
    logic        tick;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // one wait state: the read mux is registered before waitrequest drops
    wire        req      = avs_read | avs_write;
    wire        take     = ce & req & ack_ff;
    wire [7:0]  idx      = avs_address[9:2];
    wire        aligned  = (avs_address[1:0] == 2'b00);
    wire        hit_ctrl = aligned & (idx == IDX_CTRL);
    wire        hit_hi   = aligned & (idx == IDX_RES_HI);
    wire        hit_lo   = aligned & (idx == IDX_RES_LO);
    // narrower writes that miss the low byte lane are dropped
    wire        wr_ctrl  = take & avs_write & hit_ctrl
                           & avs_byteenable[0];
    wire [7:0]  wbyte    = avs_writedata[7:0];
    wire        idle     = (state_ff == SADC_IDLE);
    // a start while busy is ignored so the active channel stays put
    wire        start_go = wr_ctrl & wbyte[CTRL_START_BIT] & idle;

    assign avs_waitrequest = req & ~(ack_ff & ce); // held while frozen
    assign avs_readdata    = rdata_ff;

    // read mux; end flag reads live, reserved bits read zero
    wire [7:0]  ctrl_rd  = {1'b0, chan_ff, eoc_ff, speed_ff, start_ff};
    wire [31:0] rd_mux   = hit_ctrl ? {24'h000000, ctrl_rd} :
                           hit_hi   ? {24'h000000, result_ff[9:2]} :
                           hit_lo   ? {30'h0, result_ff[1:0]} :
                                      32'h00000000;

    // ------------------------------------------------------------------
    // successive approximation datapath
    // ------------------------------------------------------------------
    wire        in_bits  = (state_ff == SADC_BITS);
    wire [1:0]  phase    = cnt_ff[1:0];
    // decide on the last of the bit's four clocks so the DAC has settled
    wire        sample   = tick & in_bits & (phase == PHASE_LAST);
    wire [9:0]  bit_mask = 10'(10'h001 << bit_ff);
    // comparator low means input below trial: drop the trial bit
    wire [9:0]  decided  = cmp_ff ? sar_ff : (sar_ff & ~bit_mask);
    wire        last_bit = (bit_ff == 4'h0);
    wire [9:0]  trial    = last_bit ? decided : (decided | (bit_mask >> 1));
    wire        done     = sample & last_bit;

    assign dac_code    = sar_ff;
    assign analog_chan = conv_chan_ff;
    assign conv_active = ~idle;

    // conversion clock, speed frozen for the whole conversion
    sadc_tick_gen u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .run   (~idle),
        .speed (conv_speed_ff),
        .tick  (tick)
    );

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_sar   = sar_ff;
        nxt_bit   = bit_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            SADC_IDLE: begin
                if (start_go) begin
                    nxt_state = SADC_SETUP;
                    nxt_sar   = SAR_MIDSCALE;
                    nxt_bit   = MSB_INDEX;
                    nxt_cnt   = 4'h0;
                end
            end
            SADC_SETUP: begin
                // ten set-up clocks before the first decision
                if (tick) begin
                    if (cnt_ff == SETUP_LAST) begin
                        nxt_state = SADC_BITS;
                        nxt_cnt   = 4'h0;
                    end else begin
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
            end
            SADC_BITS: begin
                if (sample) begin
                    nxt_sar = trial;
                    nxt_cnt = 4'h0;
                    nxt_bit = bit_ff - 4'h1;
                    if (last_bit) begin
                        nxt_state = SADC_IDLE;
                        nxt_bit   = 4'h0;
                    end
                end else if (tick) begin
                    nxt_cnt = cnt_ff + 4'h1;
                end
            end
            default: begin
                nxt_state = SADC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // comparator synchroniser, second stage is the only reader
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_meta_ff <= 1'b0;
            cmp_ff      <= 1'b0;
        end else if (ce) begin
            cmp_meta_ff <= cmp_in;
            cmp_ff      <= cmp_meta_ff;
        end
    end

    // bus handshake and registered read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else if (ce) begin
            ack_ff   <= req & ~ack_ff;
            rdata_ff <= rd_mux;
        end
    end

    // control fields; end flag is never written from the bus
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_ff  <= CTRL_RESET[CTRL_CHAN_LSB +: 3];
            speed_ff <= CTRL_RESET[CTRL_SPEED_LSB +: 2];
        end else if (wr_ctrl) begin
            chan_ff  <= wbyte[CTRL_CHAN_LSB +: 3];
            speed_ff <= wbyte[CTRL_SPEED_LSB +: 2];
        end
    end

    // start and end flags; set and clear never meet since a start
    // is only taken while idle and completion only happens while busy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_ff <= CTRL_RESET[CTRL_START_BIT];
            eoc_ff   <= CTRL_RESET[CTRL_EOC_BIT];
        end else if (start_go) begin
            start_ff <= 1'b1;
            eoc_ff   <= 1'b0;
        end else if (done) begin
            start_ff <= 1'b0;
            eoc_ff   <= 1'b1;
        end
    end

    // per-conversion copies of channel and speed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_chan_ff  <= CTRL_RESET[CTRL_CHAN_LSB +: 3];
            conv_speed_ff <= CTRL_RESET[CTRL_SPEED_LSB +: 2];
        end else if (start_go) begin
            conv_chan_ff  <= wbyte[CTRL_CHAN_LSB +: 3];
            conv_speed_ff <= wbyte[CTRL_SPEED_LSB +: 2];
        end
    end

    // sequencer and result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff  <= SADC_IDLE;
            sar_ff    <= RESULT_RESET;
            bit_ff    <= 4'h0;
            cnt_ff    <= 4'h0;
            result_ff <= RESULT_RESET;
        end else if (ce) begin
            state_ff  <= nxt_state;
            sar_ff    <= nxt_sar;
            bit_ff    <= nxt_bit;
            cnt_ff    <= nxt_cnt;
            if (done) begin
                result_ff <= trial;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // helper: enabled cycles spent busy since the start
    logic [10:0] busy_cyc_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cyc_ff <= 11'h000;
        end else if (ce) begin
            busy_cyc_ff <= idle ? 11'h000 : busy_cyc_ff + 11'h001;
        end
    end

    a_conv_length: assert property (
        @(posedge clk) disable iff (!rst_b)
        done |-> (int'(busy_cyc_ff) + 1 ==
                  CONV_CLKS * (4 << conv_speed_ff)))
        else $error("conversion length does not match fifty clocks");

    a_base_speed: assert property (
        @(posedge clk) disable iff (!rst_b)
        (tick && conv_speed_ff == 2'b00) |-> (busy_cyc_ff[1:0] == 2'b11))
        else $error("base conversion clock is not four cpu clocks");

    a_chan_stable: assert property (
        @(posedge clk) disable iff (!rst_b)
        (conv_active && $past(conv_active)) |->
            $stable(analog_chan))
        else $error("channel changed during a conversion");

    a_start_mid: assert property (
        @(posedge clk) disable iff (!rst_b)
        start_go |=> (dac_code == 10'h200 && conv_active && !eoc_ff))
        else $error("conversion did not begin at midscale");

    a_done_idle: assert property (
        @(posedge clk) disable iff (!rst_b)
        done |=> (eoc_ff && !start_ff && !conv_active
                  && result_ff == $past(trial)))
        else $error("completion did not flag, store and go idle");

    a_eoc_readonly: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_ctrl && !start_go && !done) |=> $stable(eoc_ff))
        else $error("bus write altered the end flag");

    a_byte_only: assert property (
        @(posedge clk) disable iff (!rst_b)
        (take && avs_write && !avs_byteenable[0]) |=>
            ($stable(chan_ff) && $stable(speed_ff)))
        else $error("write without low byte lane changed control");

    a_chan_write: assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_ctrl |=> (chan_ff == $past(wbyte[6:4])))
        else $error("channel field did not take the written value");

    a_sample_only: assert property (
        @(posedge clk) disable iff (!rst_b)
        (in_bits && $past(in_bits) && $changed(sar_ff)) |->
            $past(sample))
        else $error("trial code changed off the fourth clock");

    a_result_split: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ack_ff && avs_read && hit_hi && $past(ce)
         && $stable(result_ff)) |->
            (avs_readdata == {24'h000000, result_ff[9:2]}))
        else $error("high result register shows wrong bits");

endmodule

/* File: sadc_pkg.sv */
/*
 * Shared constants for the successive-approximation converter control:
 * register indices, control field positions, reset values, timing counts
 * and the sequencer state encoding.
 * Assumes a single CPU clock domain and 32-bit Avalon-MM register access.
 */
package sadc_pkg;

    // ------------------------------------------------------------------
    // register map (index; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL    = 8'hf7;
    localparam logic [7:0] IDX_RES_HI  = 8'hf8;
    localparam logic [7:0] IDX_RES_LO  = 8'hf9;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SPEED_LSB = 1;
    localparam int CTRL_EOC_BIT   = 3;
    localparam int CTRL_CHAN_LSB  = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // conversion constants
    // ------------------------------------------------------------------
    localparam logic [9:0] SAR_MIDSCALE = 10'h200;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [3:0] MSB_INDEX    = 4'h9;
    localparam logic [3:0] SETUP_LAST   = 4'h9;  // ten set-up clocks
    localparam logic [1:0] PHASE_LAST   = 2'h3;  // four clocks per bit
    localparam int CONV_CLKS            = 50;    // whole conversion
    localparam logic [5:0] BASE_DIV     = 6'h04; // cpu clocks per conv clk

    // ------------------------------------------------------------------
    // sequencer states, gray along idle -> setup -> bits
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SADC_IDLE  = 2'b00,
        SADC_SETUP = 2'b01,
        SADC_BITS  = 2'b11
    } sadc_state_e;

endpackage

/* File: sadc_tick_gen.sv */
/*
 * Conversion clock generator: one-cycle tick every (4 << speed) enabled
 * CPU clocks while run is high; restarts from zero whenever run is low.
 * Assumes clk is the CPU clock and ce freezes the count.
 */
`timescale 1ns/1ps
module sadc_tick_gen
    import sadc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [1:0] speed,
    output logic            tick
);

    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    wire  [5:0] last_cnt = 6'(BASE_DIV << speed) - 6'h01;
    wire        at_last  = (cnt_ff == last_cnt);

    // ------------------------------------------------------------------
    // divider; held at zero between conversions so phase is known
    // ------------------------------------------------------------------
    assign tick    = ce & run & at_last;
    assign nxt_cnt = (!run || at_last) ? 6'h00 : cnt_ff + 6'h01;

    // count only while enabled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 6'h00;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

/* File: sadc_analog_model.sv */
/*
 * Behavioural far side of the converter: eight analogue input levels, the
 * resistor-string DAC and the comparator, all as plain numbers.
 * Assumes the bench holds each level still during a conversion.
 */
`timescale 1ns/1ps
module sadc_analog_model
    import sadc_pkg::*;
(
    input  wire logic [2:0]      analog_chan,
    input  wire logic [9:0]      dac_code,
    input  wire logic [7:0][9:0] levels,
    output logic                 cmp_in
);
    // -----------------------------------------------------------------
    // comparator
    // -----------------------------------------------------------------
    // only the selected input reaches the comparator; there is no
    // sample-and-hold, so a level that moves mid-run corrupts the result;
    // the shared pins are taken as already switched to analogue inputs
    assign cmp_in = (levels[analog_chan] >= dac_code);
endmodule

/* File: sar_adc_sequencer_tb.sv */
/*
 * Self-checking bench for the converter control: register access over
 * Avalon-MM, conversions at all four speeds, protected bits, busy starts
 * and a clock-enable freeze during a conversion and a bus write.
 * Assumes sadc_pkg and the analogue model are compiled first.
 */
`timescale 1ns/1ps
module sar_adc_sequencer_tb
    import sadc_pkg::*;
;
    localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] A_HI   = {IDX_RES_HI, 2'b00};
    localparam logic [9:0] A_LO   = {IDX_RES_LO, 2'b00};

    logic            clk;
    logic            rst_b;
    logic            ce;
    logic [9:0]      avs_address;
    logic            avs_read;
    logic            avs_write;
    logic [31:0]     avs_writedata;
    logic [3:0]      avs_byteenable;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic            cmp_in;
    logic [9:0]      dac_code;
    logic [2:0]      analog_chan;
    logic            conv_active;
    logic [7:0][9:0] levels;
    int              failures;
    int              n_checks;

    sadc_sequencer dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in),
        .dac_code(dac_code), .analog_chan(analog_chan),
        .conv_active(conv_active));

    sadc_analog_model far (.analog_chan(analog_chan), .dac_code(dac_code),
        .levels(levels), .cmp_in(cmp_in));

    // 40 MHz cpu clock
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // -----------------------------------------------------------------
    // compare and bus tasks
    // -----------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one access; holds everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        // no cycle count assumed; the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr8(input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        logic [31:0] r;
        bus(1'b1, a, d, be, r);
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, 4'hf, r);
        chk_reg(r, exp);
    endtask

    // wait for the end of a conversion, returns cycles waited;
    // the watchdog bounds it
    task automatic wait_idle(output int n);
        n = 0;
        while (conv_active === 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(A_CTRL, {24'h0, CTRL_RESET});
        rd_chk(A_HI, 32'h0);
        rd_chk(A_LO, 32'h0);
        rd_chk(10'h3e8, 32'h0);
        rd_chk(10'h3dd, 32'h0);
    endtask

    // channel first, then start; timing, trial code and split result
    task automatic convert(input logic [2:0] ch, input logic [1:0] sp);
        int n;
        wr8(A_CTRL, {1'b0, ch, 1'b0, sp, 1'b0}, 4'hf);
        wr8(A_CTRL, {1'b0, ch, 1'b0, sp, 1'b1}, 4'hf);
        #1;
        chk_pin(conv_active, 32'h1);
        chk_pin(dac_code, SAR_MIDSCALE);
        chk_pin(analog_chan, ch);
        wait_idle(n);
        chk_pin(n, 50 * (4 << sp));
        chk_pin(dac_code, levels[ch]);
        rd_chk(A_CTRL, {25'h0, ch, 1'b1, sp, 1'b0});
        rd_chk(A_HI, levels[ch][9:2]);
        rd_chk(A_LO, levels[ch][1:0]);
    endtask

    // narrow write, end-flag write and result write all without effect
    task automatic t_protect();
        wr8(A_CTRL, 8'h01, 4'he);
        #1;
        chk_pin(conv_active, 32'h0);
        wr8(A_CTRL, 8'h70, 4'hf);
        rd_chk(A_CTRL, 32'h78);
        wr8(A_HI, 8'h5a, 4'hf);
        rd_chk(A_HI, levels[7][9:2]);
    endtask

    // a second start while busy must not switch the channel
    task automatic t_busy();
        int n;
        wr8(A_CTRL, 8'h21, 4'hf);
        repeat (20) @(posedge clk);
        wr8(A_CTRL, 8'h61, 4'hf);
        #1;
        chk_pin(analog_chan, 32'h2);
        rd_chk(A_CTRL, 32'h61);
        wait_idle(n);
        chk_pin(analog_chan, 32'h2);
        rd_chk(A_HI, levels[2][9:2]);
        rd_chk(A_CTRL, 32'h68);
    endtask

    // a low clock enable stretches a busy-time write and freezes the run
    task automatic t_freeze();
        int n;
        wr8(A_CTRL, 8'h51, 4'hf);
        fork
            wr8(A_CTRL, 8'h31, 4'hf);
            begin
                repeat (2) @(posedge clk);
                ce <= 1'b0;
                repeat (24) @(posedge clk);
                ce <= 1'b1;
            end
        join
        chk_pin(analog_chan, 32'h5);
        wait_idle(n);
        // three enabled edges passed while the write was held
        chk_pin(n, 50 * 4 - 3);
        chk_pin(dac_code, levels[5]);
        rd_chk(A_CTRL, 32'h38);
    endtask

    // -----------------------------------------------------------------
    // run control
    // -----------------------------------------------------------------
    task automatic stop_test();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // all scenarios need under a tenth of this span
    initial begin
        #1_000_000;
        failures++;
        stop_test();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        // boundary codes on channels 3 and 5
        levels = {10'h155, 10'h0f0, 10'h000, 10'h0f0,
                  10'h3ff, 10'h1c8, 10'h0f0, 10'h2a7};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        convert(3'h0, 2'h0);
        convert(3'h3, 2'h1);
        convert(3'h5, 2'h2);
        convert(3'h7, 2'h3);
        t_protect();
        t_busy();
        t_freeze();
        stop_test();
    end
endmodule
